// ---- logic/vreg_dev.sv ----
`timescale 1ns/1ns
module vreg_dev
	import vreg_pkg::*;
#(
	parameter logic [31:0] TUNE_CYCLES = TUNE_CYC,
	parameter logic [31:0] SEC_CYCLES = SEC_CYC,
	parameter logic [31:0] MIN_CYCLES = MIN_CYC,
	parameter logic [31:0] INIT_CYCLES = INIT_CYC,
	parameter logic [31:0] PGD_CYCLES = PGD_CYC
) (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	vreg_link_if.dev link,
	input wire logic en_pin_i,
	input wire logic [4:0] strap_code_i,
	input wire logic ramp_done_i,
	input wire logic [15:0] coef_raw_i,
	output logic init_done_o,
	output logic out_en_o,
	output logic output_good_pin_o,
	output logic [15:0] vout_target_o,
	output logic [15:0] coef_o,
	output logic [15:0] nonlinear_transient_boost_o,
	output logic tune_busy_o
);
	typedef enum logic [4:0] {
		S_OFF = 5'b00001, S_RAMP = 5'b00010, S_TUNE = 5'b00100, S_PGDLY = 5'b01000, S_ON = 5'b10000
	} out_st_t;
	typedef struct packed {
		logic [4:0] s1;
		logic [4:0] s2;
		logic [4:0] strap_s1;
		logic [4:0] strap_s2;
		logic lclk_prev;
		logic [4:0] bitn;
		logic [23:0] rx;
		logic [15:0] tx;
		logic miso;
		logic init_done;
		logic [31:0] init_cnt;
		logic [15:0] nom;
		logic [15:0] ceil_mv;
		logic [15:0] vcmd;
		logic [15:0] mhi;
		logic [15:0] mlo;
		logic [15:0] vmax;
		logic [15:0] trim;
		logic [7:0] oper;
		logic [2:0] onoff;
		logic [2:0] tcfg;
		logic [7:0] gain;
		logic [15:0] boost;
		out_st_t st;
		logic [31:0] cnt;
		logic [31:0] per;
		logic tbusy;
		logic [31:0] tcnt;
		logic have_coef;
		logic [15:0] coef;
		logic out_en;
		logic pg;
		logic [15:0] vout;
	} dev_state_t;
	dev_state_t q, d;

	function automatic logic [15:0] scale_mv(input logic [15:0] v, input logic [7:0] num, input logic [7:0] den);
		logic [23:0] p;
		p = 24'(v) * 24'(num);
		return 16'(p / 24'(den));
	endfunction : scale_mv

	function automatic logic [15:0] strap_mv(input logic [4:0] idx);
		logic [15:0] r;
		if (idx == 5'h0) begin
			r = STRAP_SHORT_MV;
		end else if (idx <= STRAP_LAST_FINE) begin
			r = STRAP_SHORT_MV + 16'(idx - 5'h1) * STRAP_STEP_LO;
		end else if (idx <= STRAP_LAST) begin
			r = STRAP_HI_BASE + 16'(idx - 5'h10) * STRAP_STEP_HI;
		end else begin
			r = STRAP_OPEN_MV;
		end
		return r;
	endfunction : strap_mv

	assign link.link_miso = q.miso;
	assign init_done_o = q.init_done;
	assign out_en_o = q.out_en;
	assign output_good_pin_o = q.pg;
	assign vout_target_o = q.vout;
	assign coef_o = q.coef;
	assign nonlinear_transient_boost_o = q.boost;
	assign tune_busy_o = q.tbusy;

	logic lclk, sel_n, mosi, pin, ramp_done, rise, fall, wr, pin_on, en, start, tdone, msel;
	logic [23:0] rx_new;
	logic [7:0] hdr;
	logic [15:0] base, lim, rd_val;
	logic [16:0] sum;
	logic [31:0] per_lim;

	always_comb begin
		d = q;
		d.s1 = {ramp_done_i, en_pin_i, link.link_mosi, link.link_sel_n, link.link_clk};
		d.s2 = q.s1;
		// strap is a pin: two flops before the decoder reads it
		d.strap_s1 = strap_code_i;
		d.strap_s2 = q.strap_s1;
		{ramp_done, pin, mosi, sel_n, lclk} = q.s2;
		d.lclk_prev = lclk;
		rise = lclk && !q.lclk_prev;
		fall = !lclk && q.lclk_prev;
		rx_new = {q.rx[22:0], mosi};
		hdr = rx_new[23:16];
		wr = 1'b0;
		start = 1'b0;
		tdone = 1'b0;
		// link receive and read-back shift
		if (sel_n) begin
			d.bitn = 5'h0;
			d.miso = 1'b0;
		end else if (rise) begin
			d.rx = rx_new;
			d.bitn = q.bitn + 5'h1;
			if (q.bitn == 5'(FRAME_BITS - 1) && !hdr[CMD_RD_BIT]) begin
				wr = 1'b1;
			end
		end else if (fall && q.bitn >= 5'(HDR_BITS) && q.rx[q.bitn - 5'h1]) begin
			// the read flag entered first, so it sits bitn-1 places up the shifter
			d.miso = q.tx[15];
			d.tx = {q.tx[14:0], 1'b0};
		end
		unique case (rx_new[5:0])
			CMD_OPERATION: rd_val = {8'h00, q.oper};
			CMD_ON_OFF_CONFIG: rd_val = {13'h0, q.onoff};
			CMD_VOUT_COMMAND: rd_val = q.vcmd;
			CMD_VOUT_TRIM: rd_val = q.trim;
			CMD_VOUT_MAX: rd_val = q.vmax;
			CMD_VOUT_MARGIN_HIGH: rd_val = q.mhi;
			CMD_VOUT_MARGIN_LOW: rd_val = q.mlo;
			CMD_TUNE_CONFIG: rd_val = {13'h0, q.tcfg};
			CMD_TUNE_GAIN: rd_val = {8'h00, q.gain};
			CMD_BOOST_CONFIG: rd_val = q.boost;
			CMD_STATUS: rd_val = {8'h00, q.have_coef, q.tbusy, q.pg, q.st};
			CMD_STRAP_NOMINAL: rd_val = q.nom;
			CMD_TUNE_COEF: rd_val = q.coef;
			default: rd_val = 16'h0000;
		endcase
		// header just complete and marked read: capture the answer word
		if (!sel_n && rise && q.bitn == 5'(HDR_BITS - 1) && rx_new[CMD_RD_BIT]) begin
			d.tx = rd_val;
		end
		// initialization: strap caught once, never again until resetn_i is asserted
		if (!q.init_done) begin
			d.init_cnt = q.init_cnt + 32'h1;
			if (q.init_cnt == INIT_CYCLES - 32'h1) begin
				d.init_done = 1'b1;
				d.nom = strap_mv(q.strap_s2);
				d.ceil_mv = scale_mv(d.nom, PCT_CEIL, PCT_FULL);
				d.vcmd = d.nom;
				d.mhi = scale_mv(d.nom, PCT_MHI, PCT_FULL);
				d.mlo = scale_mv(d.nom, PCT_MLO, PCT_FULL);
			end
		end
		if (wr) begin
			unique case (hdr[5:0])
				CMD_OPERATION: begin
					// broadcast margining is not honoured in pin-only mode
					if (!(hdr[CMD_BC_BIT] && q.onoff[1:0] == SRC_PIN)) begin
						d.oper = rx_new[7:0];
					end
				end
				CMD_ON_OFF_CONFIG: d.onoff = rx_new[2:0];
				CMD_VOUT_COMMAND: d.vcmd = rx_new[15:0];
				CMD_VOUT_TRIM: d.trim = rx_new[15:0];
				CMD_VOUT_MAX: d.vmax = rx_new[15:0];
				CMD_VOUT_MARGIN_HIGH: d.mhi = rx_new[15:0];
				CMD_VOUT_MARGIN_LOW: d.mlo = rx_new[15:0];
				CMD_TUNE_CONFIG: d.tcfg = rx_new[2:0];
				CMD_TUNE_TRIGGER: start = 1'b1;
				CMD_TUNE_GAIN: begin
					// out-of-range gain is pinned to the nearest end
					if (rx_new[7:0] < GAIN_MIN) begin
						d.gain = GAIN_MIN;
					end else if (rx_new[7:0] > GAIN_MAX) begin
						d.gain = GAIN_MAX;
					end else begin
						d.gain = rx_new[7:0];
					end
				end
				CMD_BOOST_CONFIG: d.boost = rx_new[15:0];
				default: ;
			endcase
		end
		// enable source and pin polarity
		pin_on = q.onoff[ONOFF_POL_BIT] ? pin : !pin;
		unique case (q.onoff[1:0])
			SRC_PIN: en = pin_on;
			SRC_OPER: en = q.oper[OP_ON_BIT];
			SRC_BOTH: en = pin_on && q.oper[OP_ON_BIT];
			SRC_ALWAYS: en = 1'b1;
		endcase
		en = en && q.init_done;
		// output sequencing
		per_lim = (q.tcfg[1:0] == TUNE_MIN) ? MIN_CYCLES : SEC_CYCLES;
		d.cnt = 32'h0;
		d.per = 32'h0;
		if (!en) begin
			d.st = S_OFF;
			d.out_en = 1'b0;
			d.pg = 1'b0;
		end else begin
			unique case (q.st)
				S_OFF: begin
					d.out_en = 1'b1;
					d.st = S_RAMP;
				end
				S_RAMP: begin
					if (ramp_done) begin
						if (q.tcfg[1:0] == TUNE_OFF) begin
							d.st = S_PGDLY;
						end else if (q.tcfg[TCFG_POWERUP_BIT] && q.have_coef) begin
							d.st = S_ON; // held coefficients reused
							d.pg = 1'b1;
						end else begin
							start = 1'b1;
							d.st = S_TUNE;
						end
					end
				end
				S_TUNE: begin
					if (q.tbusy && q.tcnt == TUNE_CYCLES - 32'h1) begin
						d.st = S_ON;
						d.pg = 1'b1;
					end
				end
				S_PGDLY: begin
					d.cnt = q.cnt + 32'h1;
					if (q.cnt == PGD_CYCLES - 32'h1) begin
						d.st = S_ON;
						d.pg = 1'b1;
					end
				end
				S_ON: begin
					// period timer only runs while regulating and restarts per enable
					if ((q.tcfg[1:0] == TUNE_SEC || q.tcfg[1:0] == TUNE_MIN) && !q.tbusy) begin
						d.per = q.per + 32'h1;
						if (q.per == per_lim - 32'h1) begin
							d.per = 32'h0;
							start = 1'b1;
						end
					end
				end
			endcase
		end
		// tuning engine; a trigger during a run is absorbed by that run
		if (q.tbusy) begin
			d.tcnt = q.tcnt + 32'h1;
			if (q.tcnt == TUNE_CYCLES - 32'h1) begin
				tdone = 1'b1;
				d.tbusy = 1'b0;
				d.have_coef = 1'b1;
				d.coef = scale_mv(coef_raw_i, q.gain, PCT_FULL);
			end
		end else if (start) begin
			d.tbusy = 1'b1;
			d.tcnt = 32'h0;
		end
		// setpoint: margin or command, plus trim, then clamp
		msel = 1'b1;
		unique case (q.oper[OP_MRG_LSB+:2])
			MRG_HIGH: base = q.mhi;
			MRG_LOW: base = q.mlo;
			default: begin
				base = q.vcmd;
				msel = 1'b0;
			end
		endcase
		sum = {1'b0, base} + {q.trim[15], q.trim};
		if (sum[16]) begin
			sum = 17'h0;
		end
		lim = (q.vmax < q.ceil_mv) ? q.vmax : q.ceil_mv;
		d.vout = (sum[15:0] > lim) ? lim : sum[15:0];
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			// synchronised select resets to its idle (deselected) level
			q <= '{s1: 5'h02, s2: 5'h02, strap_s1: 5'h0, strap_s2: 5'h0, lclk_prev: 1'b0, bitn: 5'h0, rx: 24'h0,
				tx: 16'h0, miso: 1'b0,
				init_done: 1'b0, init_cnt: 32'h0, nom: 16'h0, ceil_mv: 16'h0, vcmd: 16'h0, mhi: 16'h0,
				mlo: 16'h0, vmax: VMAX_RST, trim: 16'h0, oper: OPER_RST,
				onoff: ONOFF_RST,
				tcfg: TCFG_RST, gain: GAIN_RST, boost: BOOST_RST, st: S_OFF, cnt: 32'h0, per: 32'h0,
				tbusy: 1'b0, tcnt: 32'h0, have_coef: 1'b0, coef: 16'h0, out_en: 1'b0, pg: 1'b0, vout: 16'h0};
		end else begin
			q <= d;
		end
	end
endmodule : vreg_dev

// ---- logic/vreg_pkg.sv ----
package vreg_pkg;
	// link command byte: bit 7 read, bit 6 broadcast, bits 5:0 command code
	localparam int CMD_RD_BIT = 7;
	localparam int CMD_BC_BIT = 6;
	localparam logic [5:0] CMD_OPERATION = 6'h01;
	localparam logic [5:0] CMD_ON_OFF_CONFIG = 6'h02;
	localparam logic [5:0] CMD_VOUT_COMMAND = 6'h21;
	localparam logic [5:0] CMD_VOUT_TRIM = 6'h22;
	localparam logic [5:0] CMD_VOUT_MAX = 6'h24;
	localparam logic [5:0] CMD_VOUT_MARGIN_HIGH = 6'h25;
	localparam logic [5:0] CMD_VOUT_MARGIN_LOW = 6'h26;
	localparam logic [5:0] CMD_TUNE_CONFIG = 6'h30;
	localparam logic [5:0] CMD_TUNE_TRIGGER = 6'h31;
	localparam logic [5:0] CMD_TUNE_GAIN = 6'h32;
	localparam logic [5:0] CMD_BOOST_CONFIG = 6'h33;
	localparam logic [5:0] CMD_STATUS = 6'h34;
	localparam logic [5:0] CMD_STRAP_NOMINAL = 6'h35;
	localparam logic [5:0] CMD_TUNE_COEF = 6'h36;
	localparam int FRAME_BITS = 24;
	localparam int HDR_BITS = 8;
	// field positions
	localparam int OP_ON_BIT = 7;
	localparam int OP_MRG_LSB = 4;
	localparam logic [1:0] MRG_LOW = 2'h1;
	localparam logic [1:0] MRG_HIGH = 2'h2;
	localparam int ONOFF_POL_BIT = 2;
	localparam logic [1:0] SRC_PIN = 2'h0;
	localparam logic [1:0] SRC_OPER = 2'h1;
	localparam logic [1:0] SRC_BOTH = 2'h2;
	localparam logic [1:0] SRC_ALWAYS = 2'h3;
	localparam int TCFG_POWERUP_BIT = 2;
	localparam logic [1:0] TUNE_OFF = 2'h0;
	localparam logic [1:0] TUNE_ONCE = 2'h1;
	localparam logic [1:0] TUNE_SEC = 2'h2;
	localparam logic [1:0] TUNE_MIN = 2'h3;
	// reset values and gain limits
	localparam logic [7:0] OPER_RST = 8'h00;
	localparam logic [2:0] ONOFF_RST = 3'h4;
	localparam logic [2:0] TCFG_RST = 3'h1;
	localparam logic [7:0] GAIN_RST = 8'h32;
	localparam logic [7:0] GAIN_MIN = 8'h0a;
	localparam logic [7:0] GAIN_MAX = 8'h64;
	localparam logic [15:0] BOOST_RST = 16'h0123;
	localparam logic [15:0] VMAX_RST = 16'hffff;
	// strap voltages in mV and strap code ranges
	localparam logic [15:0] STRAP_SHORT_MV = 16'h0258;
	localparam logic [15:0] STRAP_OPEN_MV = 16'h04b0;
	localparam logic [15:0] STRAP_STEP_LO = 16'h0032;
	localparam logic [15:0] STRAP_STEP_HI = 16'h0064;
	localparam logic [15:0] STRAP_HI_BASE = 16'h0578;
	localparam logic [4:0] STRAP_LAST_FINE = 5'h0f;
	localparam logic [4:0] STRAP_LAST = 5'h14;
	// percent scaling
	localparam logic [7:0] PCT_CEIL = 8'h6e;
	localparam logic [7:0] PCT_MHI = 8'h69;
	localparam logic [7:0] PCT_MLO = 8'h5f;
	localparam logic [7:0] PCT_FULL = 8'h64;
	// timing
	localparam longint CLK_HZ = 50_000_000;
	localparam longint TUNE_TIME_MS = 100;
	localparam longint TUNE_SEC_S = 1;
	localparam longint TUNE_MIN_S = 60;
	localparam longint INIT_TIME_US = 1000;
	localparam longint PG_DELAY_US = 1000;
	localparam logic [31:0] TUNE_CYC = 32'(TUNE_TIME_MS * CLK_HZ / 1000);
	localparam logic [31:0] SEC_CYC = 32'(TUNE_SEC_S * CLK_HZ);
	localparam logic [31:0] MIN_CYC = 32'(TUNE_MIN_S * CLK_HZ);
	localparam logic [31:0] INIT_CYC = 32'(INIT_TIME_US * CLK_HZ / 1000000);
	localparam logic [31:0] PGD_CYC = 32'(PG_DELAY_US * CLK_HZ / 1000000);
	localparam logic [3:0] LINK_HALF_CYC = 4'h8;
endpackage : vreg_pkg

// ---- logic/vreg_link_if.sv ----
`timescale 1ns/1ns
interface vreg_link_if;
	logic link_clk;
	logic link_sel_n;
	logic link_mosi;
	logic link_miso;
	modport host (output link_clk, output link_sel_n, output link_mosi, input link_miso);
	modport dev (input link_clk, input link_sel_n, input link_mosi, output link_miso);
endinterface : vreg_link_if

// ---- logic/vreg_host.sv ----
`timescale 1ns/1ns
module vreg_host
	import vreg_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	vreg_link_if.host link,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire logic req_read_i,
	input wire logic req_bcast_i,
	input wire logic [5:0] req_code_i,
	input wire logic [15:0] req_data_i,
	input wire logic vout_guard_i,
	output logic done_o,
	output logic refused_o,
	output logic [15:0] rd_data_o
);
	typedef enum logic [1:0] {H_IDLE = 2'b01, H_RUN = 2'b10} host_st_t;
	typedef struct packed {
		logic [1:0] miso_s;
		host_st_t st;
		logic [3:0] div;
		logic [4:0] bitn;
		logic [23:0] tx;
		logic [15:0] rx;
		logic lclk;
		logic sel_n;
		logic mosi;
		logic done;
		logic refused;
		logic [15:0] rd;
	} host_state_t;
	host_state_t q, d;

	assign req_ready_o = (q.st == H_IDLE);
	assign link.link_clk = q.lclk;
	assign link.link_sel_n = q.sel_n;
	assign link.link_mosi = q.mosi;
	assign done_o = q.done;
	assign refused_o = q.refused;
	assign rd_data_o = q.rd;

	always_comb begin
		d = q;
		d.miso_s = {q.miso_s[0], link.link_miso};
		d.done = 1'b0;
		d.refused = 1'b0;
		unique case (q.st)
			H_IDLE: begin
				if (req_valid_i) begin
					// command updates are refused, not sent, inside the pre-enable window
					if (!req_read_i && req_code_i == CMD_VOUT_COMMAND && vout_guard_i) begin
						d.refused = 1'b1;
					end else begin
						// trigger and all other commands go out as one frame
						d.tx = {req_read_i, req_bcast_i, req_code_i, req_data_i};
						d.mosi = req_read_i;
						d.sel_n = 1'b0;
						d.bitn = 5'h0;
						d.div = 4'h0;
						d.st = H_RUN;
					end
				end
			end
			H_RUN: begin
				d.div = q.div + 4'h1;
				if (q.div == LINK_HALF_CYC - 4'h1) begin
					d.div = 4'h0;
					d.lclk = !q.lclk;
					if (!q.lclk) begin
						// rising edge: device sampled mosi, miso stable since previous fall
						d.rx = {q.rx[14:0], q.miso_s[1]};
						d.tx = {q.tx[22:0], 1'b0};
					end else begin
						d.mosi = q.tx[23];
						d.bitn = q.bitn + 5'h1;
						if (q.bitn == 5'(FRAME_BITS - 1)) begin
							d.sel_n = 1'b1;
							d.mosi = 1'b0;
							d.done = 1'b1;
							d.rd = q.rx;
							d.st = H_IDLE;
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i) begin
			q <= '{miso_s: 2'h0, st: H_IDLE, div: 4'h0, bitn: 5'h0, tx: 24'h0, rx: 16'h0, lclk: 1'b0,
				sel_n: 1'b1, mosi: 1'b0, done: 1'b0, refused: 1'b0, rd: 16'h0};
		end else begin
			q <= d;
		end
	end
endmodule : vreg_host

// ---- verif/vreg_link_monitor.sv ----
`timescale 1ns/1ns
module vreg_link_monitor (
	input wire logic clk_sys_i,
	input wire logic resetn_i,
	input wire logic link_clk,
	input wire logic link_sel_n,
	input wire logic link_mosi,
	input wire logic link_miso
);
	logic clk_prev_q;
	logic [4:0] rise_cnt_q;

	// rises counted per frame; cleared while deselected so a frame cut short cannot leak into the next
	always_ff @(posedge clk_sys_i) begin
		if (!resetn_i || link_sel_n) begin
			rise_cnt_q <= 5'h00;
		end else if (link_clk && !clk_prev_q) begin
			rise_cnt_q <= rise_cnt_q + 5'h01;
		end
		clk_prev_q <= link_clk;
	end

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);

	a_idle_clk_low: assert property (link_sel_n |-> !link_clk)
		else $error("link clock moving outside a frame");
	a_clk_high_phase: assert property ($rose(link_clk) |-> link_clk [*8] ##1 !link_clk)
		else $error("link clock high phase not eight cycles");
	a_clk_low_phase: assert property ($fell(link_clk) |-> !link_clk [*8])
		else $error("link clock low phase too short");
	a_first_rise: assert property ($fell(link_sel_n) |-> ##[1:9] $rose(link_clk))
		else $error("no link clock after frame start");
	a_mosi_on_fall: assert property (!link_sel_n && !$past(link_sel_n) && !$fell(link_clk) |-> $stable(link_mosi))
		else $error("host data moved away from a falling edge");
	a_miso_hold_high: assert property (!link_sel_n && link_clk |-> $stable(link_miso))
		else $error("device data moved while link clock high");
	a_frame_bits: assert property ($rose(link_sel_n) |-> rise_cnt_q == 5'h18)
		else $error("frame did not carry 24 bits");
	a_rise_cap: assert property ($rose(link_clk) |-> rise_cnt_q < 5'h18)
		else $error("more than 24 link clocks in a frame");
endmodule : vreg_link_monitor

// ---- verif/vout_setpoint_and_loop_tuning_tb.sv ----
`timescale 1ns/1ns
module vout_setpoint_and_loop_tuning_tb;
	logic clk, resetn, valid, rd, bc, guard, en_pin, ramp, refd;
	logic ready, done, refused, init_done, out_en, pg, busy;
	logic [15:0] rdata, vout, coef, boost, q, data, coef_raw;
	logic [5:0] code;
	logic [4:0] strap;
	logic [5:0] cv [7];
	int ev [7];
	int n_errors = 0;
	int checks_done = 0;
	int nom, wn, g, cmd, trim, vmax, mh, ml, m, sc;

	vreg_link_if vreg_link_if_inst ();
	vreg_host vreg_host_inst (.clk_sys_i(clk), .resetn_i(resetn), .link(vreg_link_if_inst), .req_valid_i(valid),
		.req_ready_o(ready), .req_read_i(rd), .req_bcast_i(bc), .req_code_i(code), .req_data_i(data),
		.vout_guard_i(guard), .done_o(done), .refused_o(refused), .rd_data_o(rdata));
	// short counts keep the run small: tune 20, 1 s 200, 1 min 400, init 10, good delay 8
	// one standalone regulator, so adaptive tuning may stay enabled
	// internal clock only: no external sync source to settle before enabling
	vreg_dev #(.TUNE_CYCLES(32'h14), .SEC_CYCLES(32'hc8), .MIN_CYCLES(32'h190), .INIT_CYCLES(32'ha),
		.PGD_CYCLES(32'h8)) vreg_dev_inst (.clk_sys_i(clk), .resetn_i(resetn), .link(vreg_link_if_inst),
		.en_pin_i(en_pin), .strap_code_i(strap), .ramp_done_i(ramp), .coef_raw_i(coef_raw),
		.init_done_o(init_done), .out_en_o(out_en), .output_good_pin_o(pg), .vout_target_o(vout), .coef_o(coef),
		.nonlinear_transient_boost_o(boost), .tune_busy_o(busy));
	vreg_link_monitor vreg_link_monitor_inst (.clk_sys_i(clk), .resetn_i(resetn),
		.link_clk(vreg_link_if_inst.link_clk),
		.link_sel_n(vreg_link_if_inst.link_sel_n), .link_mosi(vreg_link_if_inst.link_mosi),
		.link_miso(vreg_link_if_inst.link_miso));

	always #10 clk = ~clk;

	task automatic test_done();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : test_done

	task automatic ck(input string s, input logic [15:0] e, input logic [15:0] v);
		checks_done++;
		if (v !== e) begin
			$display("[ERR] %s exp %h got %h", s, e, v);
			n_errors++;
		end
	endtask : ck

	function automatic logic sg(input int k);
		return k == 0 ? out_en : k == 1 ? pg : k == 2 ? busy : init_done;
	endfunction : sg

	task automatic wt(input int k, input logic v, input int lim);
		wn = 0;
		while (sg(k) !== v && wn < lim) begin
			@(negedge clk);
			wn++;
		end
		ck("wait", {15'h0, v}, {15'h0, sg(k)});
	endtask : wt

	// request held until ready is seen high before the taking edge
	task automatic xfer(input logic r, input logic b, input logic [5:0] c, input logic [15:0] d);
		int n;
		n = 0;
		@(posedge clk);
		valid <= 1'b1;
		rd <= r;
		bc <= b;
		code <= c;
		data <= d;
		@(negedge clk);
		while (ready !== 1'b1 && n < 900) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		valid <= 1'b0;
		@(negedge clk);
		while (done !== 1'b1 && refused !== 1'b1 && n < 900) begin
			@(negedge clk);
			n++;
		end
		refd = refused;
		q = rdata;
		ck("xfer_end", 16'h0001, {15'h0, n < 900});
	endtask : xfer

	task automatic rst(input logic [4:0] s);
		@(posedge clk);
		resetn <= 1'b0;
		strap <= s;
		// output stays off after reset so the first ramp is the bench's own
		en_pin <= 1'b0;
		ramp <= 1'b0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		wt(3, 1'b1, 40);
		@(posedge clk);
		strap <= 5'($urandom % 32);
	endtask : rst

	// the analog ramp only completes after the output is switched on
	task automatic cyc();
		@(posedge clk);
		en_pin <= 1'b0;
		ramp <= 1'b0;
		wt(0, 1'b0, 10);
		@(posedge clk);
		en_pin <= 1'b1;
		wt(0, 1'b1, 10);
		@(posedge clk);
		ramp <= 1'b1;
	endtask : cyc

	function automatic int nomf(input int c);
		if (c == 0) return 600;
		if (c <= 15) return 550 + c * 50;
		if (c <= 20) return 1400 + (c - 16) * 100;
		return 1200;
	endfunction : nomf

	function automatic logic enx(input int s, input logic p, input logic pin, input logic on);
		case (s)
			0: return pin == p;
			1: return on;
			2: return (pin == p) && on;
			default: return 1'b1;
		endcase
	endfunction : enx

	function automatic int vx(input int b, input int t, input int mx);
		int v;
		int lim;
		v = b + t < 0 ? 0 : b + t;
		lim = nom * 110 / 100;
		lim = mx < lim ? mx : lim;
		return v > lim ? lim : v;
	endfunction : vx

	initial begin
		repeat (80000) @(posedge clk);
		n_errors++;
		test_done();
	end

	initial begin
		{clk, resetn, valid, rd, bc, guard, en_pin, ramp} = '0;
		code = '0;
		data = '0;
		strap = '0;
		coef_raw = '0;
		void'($urandom(32'h313c6133));
		cv = '{6'h35, 6'h25, 6'h26, 6'h02, 6'h30, 6'h32, 6'h24};
		for (int p = 0; p < 3; p++) begin
			sc = p == 0 ? 0 : p == 1 ? 31 : $urandom % 23;
			rst(5'(sc));
			nom = nomf(sc);
			ev = '{nom, nom * 105 / 100, nom * 95 / 100, 4, 1, 50, 65535};
			for (int k = 0; k < 7; k++) begin
				xfer(1'b1, 1'b0, cv[k], 16'h0);
				ck("reg", 16'(ev[k]), q);
			end
			ck("boost", 16'h0123, boost);
		end
		mh = $urandom;
		xfer(1'b0, 1'b0, 6'h33, 16'(mh));
		ck("boost_wr", 16'(mh), boost);
		xfer(1'b0, 1'b0, 6'h32, 16'h0005);
		xfer(1'b1, 1'b0, 6'h32, 16'h0);
		ck("gain_min", 16'h000a, q);
		$display("test reset_and_strap done");
		for (int i = 0; i < 8; i++) begin
			m = $urandom;
			xfer(1'b0, 1'b0, 6'h02, 16'({m[0], 2'(i)}));
			xfer(1'b0, 1'b0, 6'h01, {8'h00, m[2], 7'h00});
			@(posedge clk);
			en_pin <= m[1];
			repeat (10) @(negedge clk);
			ck("out_en", {15'h0, enx(i % 4, m[0], m[1], m[2])}, {15'h0, out_en});
		end
		$display("test enable_source done");
		xfer(1'b0, 1'b0, 6'h02, 16'h0007);
		for (int i = 0; i < 6; i++) begin
			cmd = 400 + $urandom % 1800;
			trim = i == 0 ? 0 : $urandom % 201 - 100;
			vmax = i % 2 ? 65535 : 500 + $urandom % 1500;
			mh = $urandom % 2000;
			ml = $urandom % 2000;
			xfer(1'b0, 1'b0, 6'h21, 16'(cmd));
			xfer(1'b0, 1'b0, 6'h22, 16'(trim));
			xfer(1'b0, 1'b0, 6'h24, 16'(vmax));
			xfer(1'b0, 1'b0, 6'h25, 16'(mh));
			xfer(1'b0, 1'b0, 6'h26, 16'(ml));
			xfer(1'b0, 1'b0, 6'h01, {8'h00, 2'h2, 2'(i % 3), 4'h0});
			xfer(1'b1, 1'b0, 6'h21, 16'h0);
			ck("vcmd", 16'(cmd), q);
			ck("vout", 16'(vx(i % 3 == 1 ? ml : i % 3 == 2 ? mh : cmd, trim, vmax)), vout);
		end
		for (int j = 0; j < 2; j++) begin
			xfer(1'b0, 1'b0, 6'h01, 16'h0080);
			xfer(1'b0, 1'b0, 6'h02, 16'(4 + j));
			xfer(1'b0, 1'b1, 6'h01, 16'h00a0);
			ck("bcast_vout", 16'(vx(j ? mh : cmd, trim, vmax)), vout);
		end
		@(posedge clk);
		guard <= 1'b1;
		xfer(1'b0, 1'b0, 6'h21, 16'h0100);
		ck("refused", 16'h0001, {15'h0, refd});
		@(posedge clk);
		guard <= 1'b0;
		xfer(1'b1, 1'b0, 6'h21, 16'h0);
		ck("vcmd_kept", 16'(cmd), q);
		$display("test setpoint done");
		xfer(1'b0, 1'b0, 6'h02, 16'h0004);
		g = 10 + $urandom % 91;
		xfer(1'b0, 1'b0, 6'h32, 16'(g));
		@(posedge clk);
		coef_raw <= 16'($urandom);
		cyc();
		wt(2, 1'b1, 10);
		ck("pg_early", 16'h0, {15'h0, pg});
		wt(1, 1'b1, 25);
		ck("tune_len", 16'h0001, {15'h0, wn >= 18});
		ck("coef", 16'(coef_raw * g / 100), coef);
		@(posedge clk);
		coef_raw <= 16'($urandom);
		xfer(1'b0, 1'b0, 6'h31, 16'h0);
		wt(2, 1'b1, 10);
		wt(2, 1'b0, 30);
		ck("coef_trig", 16'(coef_raw * g / 100), coef);
		for (int t = 2; t < 4; t++) begin
			xfer(1'b0, 1'b0, 6'h30, 16'(t));
			wt(2, 1'b1, t * 240);
			wt(2, 1'b0, 30);
			wt(2, 1'b1, t * 240);
			ck("period", 16'h0001, {15'h0, wn >= (t - 1) * 200 - 30});
		end
		@(posedge clk);
		en_pin <= 1'b0;
		repeat (450) @(negedge clk);
		ck("no_rerun_off", 16'h0, {15'h0, busy});
		xfer(1'b0, 1'b0, 6'h30, 16'h0000);
		cyc();
		repeat (3) @(negedge clk);
		ck("pg_delay", 16'h0, {14'h0, pg, busy});
		wt(1, 1'b1, 20);
		$display("test tuning done");
		rst(5'(sc));
		xfer(1'b0, 1'b0, 6'h30, 16'h0005);
		cyc();
		wt(2, 1'b1, 10);
		wt(1, 1'b1, 30);
		cyc();
		wt(1, 1'b1, 10);
		ck("reuse_coef", 16'h0, {15'h0, busy});
		$display("test power_up_tuning done");
		test_done();
	end
endmodule : vout_setpoint_and_loop_tuning_tb
